// File: lfch_pkg.sv
package lfch_pkg;

    // ****************************************************************
    // Configuration space map
    // ****************************************************************
    localparam int          CFG_ADDR_W         = 8;
    localparam logic [7:0]  OFF_TENURE_LINE    = 8'h0c;
    localparam logic [7:0]  OFF_HEADER_SELFTST = 8'h0e;
    localparam logic [7:0]  OFF_LINK_BASE      = 8'h10;
    localparam logic [7:0]  OFF_VENDOR_BASE    = 8'h14;

    // ****************************************************************
    // Field positions inside the dword at 0x0c
    // ****************************************************************
    localparam int          LINE_LSB           = 0;
    localparam int          TENURE_LSB         = 8;
    localparam int          LAYOUT_LSB         = 16;
    localparam int          SELFTEST_LSB       = 24;

    // ****************************************************************
    // Base address fields
    // ****************************************************************
    localparam int          PTR_LSB            = 11;
    localparam int          PTR_W              = 21;
    localparam logic [10:0] BASE_LOW_BITS      = 11'h000;

    // ****************************************************************
    // Reset and fixed values
    // ****************************************************************
    localparam logic [7:0]  TENURE_RST         = 8'h00;
    localparam logic [7:0]  LINE_RST           = 8'h00;
    localparam logic [7:0]  LAYOUT_VAL         = 8'h00;
    localparam logic [7:0]  SELFTEST_VAL       = 8'h00;
    localparam logic [20:0] PTR_RST            = 21'h000000;
    localparam logic [7:0]  CNT_MAX            = 8'hff;

    // Tenure tracking states, one-hot
    typedef enum logic [2:0] {
        TEN_IDLE    = 3'b001,
        TEN_COUNT   = 3'b010,
        TEN_EXPIRED = 3'b100
    } lfch_tenure_t;

    // Configuration access request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } lfch_cfg_req_t;

    // Configuration access answer
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } lfch_cfg_rsp_t;

    // Initiator side status
    typedef struct packed {
        logic init_active;
        logic gnt_n;
    } lfch_mst_t;

    // Whole block state
    typedef struct packed {
        lfch_tenure_t  fsm;
        logic [7:0]    tenure_cnt;
        logic [7:0]    tenure_limit;
        logic [7:0]    line_len;
        logic [20:0]   link_ptr;
        logic [20:0]   vendor_ptr;
        lfch_cfg_rsp_t rsp;
        logic          stop_req;
    } lfch_state_t;

endpackage

// File: lfch_top.sv
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// [RULE1] Tenure counter starts at zero, counts clocks
// [RULE2] Expired tenure ends transfer once grant drops
// [RULE3] Line length drives line-oriented read/write commands
// [RULE4] Self-test byte always reads zero
// [RULE5] Header layout byte always reads zero
// [RULE6] All-ones write to link base reads FFFFF800
// [RULE7] Link base bits 31-11 hold written address
// [RULE8] Link base bits 10-4 read zero
// [RULE9] Link base bit 3 reads zero
// [RULE10] Link base bits 2-1 read zero
// [RULE11] Link base bit 0 reads zero
// [RULE12] Vendor base bits 31-11 hold written address
// [RULE13] Vendor base bits 10-4 read zero
// [RULE14] Vendor base bit 3 reads zero
// [RULE15] Vendor base bits 2-1 read zero
// [RULE16] Vendor base bit 0 reads zero
// [RULE17] Tenure and line register at 0x0c, reset 0000
// [RULE18] Tenure counter clears when transfer ends
module lfch_top (
    input  wire logic                   clock_in,      // 125 MHz
    input  wire logic                   nrst_in,       // Async, active low
    input  wire lfch_pkg::lfch_cfg_req_t cfg_req_in,   // Config access
    input  wire lfch_pkg::lfch_mst_t    mst_in,        // Initiator status
    output var  lfch_pkg::lfch_cfg_rsp_t cfg_rsp_out,  // Config answer
    output logic [7:0]                  line_length_setting_out,
    output logic [7:0]                  tenure_count_out,
    output logic                        stop_req_out,
    output logic [20:0]                 link_regs_base_pointer_out,
    output logic [20:0]                 vendor_ext_base_pointer_out
);
    import lfch_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    lfch_state_t s_q;   // Registered state
    lfch_state_t s_d;   // Next state

    // Dword index of an address
    function automatic logic [5:0] dw_idx(input logic [7:0] a);
        dw_idx = a[7:2];
    endfunction

    // Byte enables expanded to a bit mask
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // Merge a write into a base register, keep only the pointer
    function automatic logic [20:0] merge_ptr(
        input logic [20:0] old_ptr,
        input logic [31:0] wdata,
        input logic [3:0]  be
    );
        logic [31:0] old_w;
        logic [31:0] m;
        logic [31:0] nw;
        old_w     = {old_ptr, BASE_LOW_BITS};
        m         = be_mask(be);
        nw        = (old_w & ~m) | (wdata & m);
        merge_ptr = nw[31:PTR_LSB];
    endfunction

    // Read data for a dword; unmapped space reads as zero
    function automatic logic [31:0] read_dw(
        input logic [7:0]  a,
        input lfch_state_t st
    );
        read_dw = 32'h00000000;
        if (dw_idx(a) == dw_idx(OFF_TENURE_LINE)) begin
            // Upper half is the fixed layout and self-test pair
            read_dw = {SELFTEST_VAL, LAYOUT_VAL,           // [RULE4] [RULE5]
                       st.tenure_limit, st.line_len};      // [RULE17]
        end else if (dw_idx(a) == dw_idx(OFF_LINK_BASE)) begin
            // Low bits fixed: 2K size, no prefetch, 32-bit, memory
            read_dw = {st.link_ptr,                        // [RULE8] [RULE9]
                       BASE_LOW_BITS};                     // [RULE10] [RULE11]
        end else if (dw_idx(a) == dw_idx(OFF_VENDOR_BASE)) begin
            read_dw = {st.vendor_ptr,                      // [RULE13] [RULE14]
                       BASE_LOW_BITS};                     // [RULE15] [RULE16]
        end
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_d           = s_q;
        s_d.rsp.ack   = 1'b0;

        // Register writes; header bytes of 0x0c are read only
        if (cfg_req_in.wr) begin
            if (dw_idx(cfg_req_in.addr) == dw_idx(OFF_TENURE_LINE)) begin
                if (cfg_req_in.be[0]) begin
                    s_d.line_len = cfg_req_in.wdata[LINE_LSB +: 8]; // [RULE3]
                end
                if (cfg_req_in.be[1]) begin
                    s_d.tenure_limit =
                        cfg_req_in.wdata[TENURE_LSB +: 8];          // [RULE17]
                end
            end else if (dw_idx(cfg_req_in.addr) ==
                         dw_idx(OFF_LINK_BASE)) begin
                s_d.link_ptr = merge_ptr(s_q.link_ptr,
                    cfg_req_in.wdata, cfg_req_in.be);  // [RULE6] [RULE7]
            end else if (dw_idx(cfg_req_in.addr) ==
                         dw_idx(OFF_VENDOR_BASE)) begin
                // Whole 21-bit pointer is writable, not 20 bits
                s_d.vendor_ptr = merge_ptr(s_q.vendor_ptr,
                    cfg_req_in.wdata, cfg_req_in.be);  // [RULE12]
            end
        end

        // Every access is answered one clock later
        if (cfg_req_in.rd || cfg_req_in.wr) begin
            s_d.rsp.ack = 1'b1;
        end
        if (cfg_req_in.rd) begin
            // Read sees the register before a same-cycle write
            s_d.rsp.rdata = read_dw(cfg_req_in.addr, s_q);
        end

        // Tenure tracking
        unique case (s_q.fsm)
            TEN_IDLE: begin
                s_d.tenure_cnt = 8'h00;
                if (mst_in.init_active) begin
                    // Frame asserted: start from zero
                    s_d.fsm = TEN_COUNT;                      // [RULE1]
                end
            end
            TEN_COUNT: begin
                if (!mst_in.init_active) begin
                    s_d.fsm        = TEN_IDLE;                // [RULE18]
                    s_d.tenure_cnt = 8'h00;
                end else if (s_q.tenure_cnt == s_q.tenure_limit) begin
                    s_d.fsm = TEN_EXPIRED;                    // [RULE2]
                end
                if (mst_in.init_active && s_q.tenure_cnt != CNT_MAX) begin
                    s_d.tenure_cnt = s_q.tenure_cnt + 8'h01;  // [RULE1]
                end
            end
            TEN_EXPIRED: begin
                if (!mst_in.init_active) begin
                    s_d.fsm        = TEN_IDLE;                // [RULE18]
                    s_d.tenure_cnt = 8'h00;
                end else if (s_q.tenure_cnt != CNT_MAX) begin
                    // Keeps counting so software sees the overrun
                    s_d.tenure_cnt = s_q.tenure_cnt + 8'h01;
                end
            end
        endcase

        // Ask the master to end only once the grant has gone away
        s_d.stop_req = (s_q.fsm == TEN_EXPIRED) && mst_in.init_active &&
                       mst_in.gnt_n;                          // [RULE2]
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_q.fsm          <= TEN_IDLE;
            s_q.tenure_cnt   <= 8'h00;
            s_q.tenure_limit <= TENURE_RST;                   // [RULE17]
            s_q.line_len     <= LINE_RST;                     // [RULE17]
            s_q.link_ptr     <= PTR_RST;
            s_q.vendor_ptr   <= PTR_RST;
            s_q.rsp          <= '0;
            s_q.stop_req     <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flops
    assign cfg_rsp_out                 = s_q.rsp;
    assign line_length_setting_out     = s_q.line_len;        // [RULE3]
    assign tenure_count_out            = s_q.tenure_cnt;
    assign stop_req_out                = s_q.stop_req;
    assign link_regs_base_pointer_out  = s_q.link_ptr;
    assign vendor_ext_base_pointer_out = s_q.vendor_ptr;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);

    // A new tenure opens with the count at zero
    property p_tenure_start;
        (s_q.fsm == TEN_IDLE && mst_in.init_active) |=>
            (s_q.fsm == TEN_COUNT && tenure_count_out == 8'h00);
    endproperty
    a_tenure_start: assert property (p_tenure_start) // [RULE1]
        else $error("Tenure count did not start at zero");

    // Two busy cycles add two; kept clear of the saturation point
    property p_tenure_advance;
        (s_q.fsm == TEN_COUNT && mst_in.init_active &&
         s_q.tenure_cnt < CNT_MAX - 8'h01) ##1 mst_in.init_active |=>
            (tenure_count_out == $past(tenure_count_out, 2) + 8'h02);
    endproperty
    a_tenure_advance: assert property (p_tenure_advance) // [RULE1]
        else $error("Tenure count did not advance per clock");

    // Reaching the programmed limit marks the tenure expired
    property p_expire;
        (s_q.fsm == TEN_COUNT && mst_in.init_active &&
         s_q.tenure_cnt == s_q.tenure_limit) |=> (s_q.fsm == TEN_EXPIRED);
    endproperty
    a_expire: assert property (p_expire) // [RULE2]
        else $error("Tenure did not expire at programmed value");

    // Expired and ungranted: the transfer must be ended
    property p_stop_on_gnt_loss;
        (s_q.fsm == TEN_EXPIRED && mst_in.init_active && mst_in.gnt_n)
            |=> stop_req_out;
    endproperty
    a_stop_on_gnt_loss: assert property (p_stop_on_gnt_loss) // [RULE2]
        else $error("Expired transfer not stopped after grant loss");

    // No stop while granted or before expiry
    property p_no_stop_granted;
        (!mst_in.gnt_n || s_q.fsm != TEN_EXPIRED) |=> !stop_req_out;
    endproperty
    a_no_stop_granted: assert property (p_no_stop_granted) // [RULE2]
        else $error("Stop requested while granted or not expired");

    // End of transfer returns the counter to idle and zero
    property p_clear_on_end;
        !mst_in.init_active |=>
            (tenure_count_out == 8'h00 && s_q.fsm == TEN_IDLE);
    endproperty
    a_clear_on_end: assert property (p_clear_on_end) // [RULE18]
        else $error("Tenure count not cleared at transfer end");

    // Line length byte takes the written byte
    property p_line_write;
        (cfg_req_in.wr && cfg_req_in.be[0] &&
         dw_idx(cfg_req_in.addr) == dw_idx(OFF_TENURE_LINE)) |=>
            (line_length_setting_out == $past(cfg_req_in.wdata[7:0]));
    endproperty
    a_line_write: assert property (p_line_write) // [RULE3]
        else $error("Line length setting not taken from write");

    // Header layout and self-test bytes always read zero
    property p_header_read;
        (cfg_req_in.rd && dw_idx(cfg_req_in.addr) ==
         dw_idx(OFF_TENURE_LINE)) |=>
            (cfg_rsp_out.ack && cfg_rsp_out.rdata[31:16] == 16'h0000 &&
             cfg_rsp_out.rdata[7:0] == $past(s_q.line_len));
    endproperty
    a_header_read: assert property (p_header_read) // [RULE4] [RULE5] [RULE17]
        else $error("Header layout or self-test byte not zero");

    // Sizing write of all ones reads back the 2K mask
    property p_link_size;
        (cfg_req_in.wr && !cfg_req_in.rd && cfg_req_in.be == 4'hf &&
         cfg_req_in.wdata == 32'hffffffff &&
         dw_idx(cfg_req_in.addr) == dw_idx(OFF_LINK_BASE)) ##1
        (cfg_req_in.rd && !cfg_req_in.wr &&
         dw_idx(cfg_req_in.addr) == dw_idx(OFF_LINK_BASE)) |=>
            (cfg_rsp_out.rdata == 32'hfffff800);
    endproperty
    a_link_size: assert property (p_link_size) // [RULE6] [RULE7]
        else $error("Link base sizing read is wrong");

    // Link base read shows the pointer over fixed low bits
    property p_link_low;
        (cfg_req_in.rd && dw_idx(cfg_req_in.addr) == dw_idx(OFF_LINK_BASE))
            |=> (cfg_rsp_out.rdata[10:0] == 11'h000 &&
                 cfg_rsp_out.rdata[31:11] == $past(s_q.link_ptr));
    endproperty
    a_link_low: assert property (p_link_low) // [RULE8][RULE9][RULE10][RULE11]
        else $error("Link base low bits not zero");

    // Vendor base read shows the pointer over a zero size field
    property p_vendor_base;
        (cfg_req_in.rd &&
         dw_idx(cfg_req_in.addr) == dw_idx(OFF_VENDOR_BASE))
            |=> (cfg_rsp_out.rdata[10:0] == 11'h000 &&
                 cfg_rsp_out.rdata[31:11] == $past(s_q.vendor_ptr));
    endproperty
    a_vendor_base: assert property (p_vendor_base) // [RULE13] [RULE14]
        else $error("Vendor base read is wrong");

    // Flag bits of a vendor base read are zero
    property p_vendor_flags;
        (cfg_req_in.rd &&
         dw_idx(cfg_req_in.addr) == dw_idx(OFF_VENDOR_BASE))
            |=> (cfg_rsp_out.rdata[3:0] == 4'h0);
    endproperty
    a_vendor_flags: assert property (p_vendor_flags) // [RULE15] [RULE16]
        else $error("Vendor base flag bits not zero");

    // A full write sets all 21 vendor pointer bits
    property p_vendor_write;
        (cfg_req_in.wr && cfg_req_in.be == 4'hf &&
         dw_idx(cfg_req_in.addr) == dw_idx(OFF_VENDOR_BASE)) |=>
            (vendor_ext_base_pointer_out == $past(cfg_req_in.wdata[31:11]));
    endproperty
    a_vendor_write: assert property (p_vendor_write) // [RULE12]
        else $error("Vendor base pointer not written");

    // Limit byte of 0x0c takes the written byte
    property p_limit_write;
        (cfg_req_in.wr && cfg_req_in.be[1] &&
         dw_idx(cfg_req_in.addr) == dw_idx(OFF_TENURE_LINE)) |=>
            (s_q.tenure_limit == $past(cfg_req_in.wdata[15:8]));
    endproperty
    a_limit_write: assert property (p_limit_write) // [RULE17]
        else $error("Tenure limit not taken from write");

    // Link pointer takes the upper 21 bits of a full write
    property p_link_write;
        (cfg_req_in.wr && cfg_req_in.be == 4'hf &&
         dw_idx(cfg_req_in.addr) == dw_idx(OFF_LINK_BASE)) |=>
            (link_regs_base_pointer_out == $past(cfg_req_in.wdata[31:11]));
    endproperty
    a_link_write: assert property (p_link_write) // [RULE7]
        else $error("Link base pointer not written");

    // Idle counter always reads zero
    property p_idle_zero;
        s_q.fsm == TEN_IDLE |-> tenure_count_out == 8'h00;
    endproperty
    a_idle_zero: assert property (p_idle_zero) // [RULE18]
        else $error("Tenure count not zero while idle");

    // Stop drops once the transfer ends or the grant returns
    property p_stop_drop;
        (!mst_in.init_active || !mst_in.gnt_n) |=> !stop_req_out;
    endproperty
    a_stop_drop: assert property (p_stop_drop) // [RULE2]
        else $error("Stop request outlived transfer or grant");

    // Every access is answered by one ack pulse a clock later
    property p_ack_pulse;
        (cfg_req_in.rd || cfg_req_in.wr) |=> cfg_rsp_out.ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) // [RULE17]
        else $error("Config access not acknowledged");

    // Main scenarios
    c_expire_stop: cover property (s_q.fsm == TEN_EXPIRED ##1 stop_req_out);
    c_link_size:   cover property (
        (cfg_req_in.wr && dw_idx(cfg_req_in.addr) == dw_idx(OFF_LINK_BASE))
        ##1 (cfg_req_in.rd &&
             dw_idx(cfg_req_in.addr) == dw_idx(OFF_LINK_BASE)));
    c_stop_drop:   cover property (stop_req_out ##1 !stop_req_out);
    c_short_xfer:  cover property (s_q.fsm == TEN_COUNT ##1
                                   s_q.fsm == TEN_IDLE);

endmodule

`default_nettype wire

// File: lfch_unused_guard.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// File: lfch_arb_model.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************************************
// Host arbiter and bus model on the initiator side
// ****************************************************************
// Opens one tenure per go pulse and holds the transaction for a
// fixed count. The grant can be withdrawn for the whole tenure.
module lfch_arb_model (
    input  wire logic                clock_in,   // Bus clock
    input  wire logic                nrst_in,    // Async, active low
    input  wire logic                go_in,      // Start a tenure
    input  wire logic [7:0]          len_in,     // Cycles of FRAME
    input  wire logic                gnt_off_in, // Grant gone in tenure
    output var  lfch_pkg::lfch_mst_t mst_out     // Initiator status
);
    import lfch_pkg::*;

    logic [7:0] left_q;                          // Tenure cycles left

    // Count the tenure down; a go during a tenure is ignored
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            left_q  <= 8'h00;
            mst_out <= '0;
        end else if (go_in && left_q == 8'h00) begin
            left_q              <= len_in;
            mst_out.init_active <= 1'b1;
            mst_out.gnt_n       <= gnt_off_in;
        end else if (left_q > 8'h01) begin
            left_q <= left_q - 8'h01;
        end else begin
            // Grant is handed back when the tenure ends
            left_q  <= 8'h00;
            mst_out <= '0;
        end
    end
endmodule

`default_nettype wire

// File: tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
    import lfch_pkg::*;

    // ****************************************************************
    // Stimulus and observed signals
    // ****************************************************************
    logic          clock_in  = 1'b0;  // 125 MHz
    logic          nrst_in   = 1'b0;  // Held low at start
    lfch_cfg_req_t req       = '0;    // Config request
    lfch_cfg_rsp_t rsp;               // Config answer
    lfch_mst_t     mst;               // From the bus model
    logic          go        = 1'b0;  // Tenure start pulse
    logic          gnt_off   = 1'b0;  // Grant withdrawn
    logic [7:0]    line_len;          // Line length output
    logic [7:0]    ten_cnt;           // Tenure counter output
    logic          stop;              // End-transfer request
    logic [20:0]   link_ptr;          // Link base pointer
    logic [20:0]   ven_ptr;           // Vendor base pointer
    logic [31:0]   exp_q[$];          // Expected read data
    logic          rd_q1     = 1'b0;  // Read taken last edge
    logic          acc_q1    = 1'b0;  // Access taken last edge
    logic [31:0]   w;                 // Random write value
    int            err_count = 0;     // Mismatches
    int            tests_run = 0;     // Comparisons

    always #4 clock_in = ~clock_in;

    lfch_top dut (
        .clock_in                    (clock_in),
        .nrst_in                     (nrst_in),
        .cfg_req_in                  (req),
        .mst_in                      (mst),
        .cfg_rsp_out                 (rsp),
        .line_length_setting_out     (line_len),
        .tenure_count_out            (ten_cnt),
        .stop_req_out                (stop),
        .link_regs_base_pointer_out  (link_ptr),
        .vendor_ext_base_pointer_out (ven_ptr)
    );

    lfch_arb_model arb (
        .clock_in   (clock_in),
        .nrst_in    (nrst_in),
        .go_in      (go),
        .len_in     (8'h0a),
        .gnt_off_in (gnt_off),
        .mst_out    (mst)
    );

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask

    // One access; a read notes its expected data for the monitor
    task automatic cfg(input logic rd, input logic wr,
                       input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] e);
        @(posedge clock_in);
        req <= {rd, wr, a, 4'hf, d};
        if (rd) begin
            exp_q.push_back(e);
        end
        @(posedge clock_in);
        req <= '0;
    endtask

    // One ten-cycle tenure; stop only once expired with grant gone
    task automatic tenure(input logic off, input logic hit);
        int k;
        @(posedge clock_in);
        go      <= 1'b1;
        gnt_off <= off;
        @(posedge clock_in);
        go <= 1'b0;
        @(negedge clock_in);
        for (k = 0; k < 4; k++) begin
            @(negedge clock_in);
            chk("count", k, {24'h0, ten_cnt});
            chk("stop early", 32'h0, {31'h0, stop});
        end
        @(negedge clock_in);
        chk("stop", {31'h0, off & hit}, {31'h0, stop});
        for (k = 0; k < 20 && mst.init_active; k++) begin
            @(negedge clock_in);
        end
        @(negedge clock_in);
        chk("count clear", 32'h0, {24'h0, ten_cnt});
        chk("stop clear", 32'h0, {31'h0, stop});
    endtask

    // Sole place where the run ends
    task automatic end_sim;
        repeat (4) @(posedge clock_in);
        if (exp_q.size() != 0) begin
            $display("BAD reads expected 0 left %0d", exp_q.size());
            err_count++;
        end
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ****************************************************************
    // Read data monitor
    // ****************************************************************
    // Ack is registered on the taking edge itself, so one stage of
    // history tells a read answer from a write answer
    always @(posedge clock_in) begin
        rd_q1  <= req.rd;
        acc_q1 <= req.rd | req.wr;
    end

    // Ack must be a single pulse after every access, reads or writes
    always @(negedge clock_in) begin
        chk("ack", {31'h0, acc_q1}, {31'h0, rsp.ack});
        if (rsp.ack === 1'b1 && rd_q1) begin
            if (exp_q.size() == 0) begin
                chk("unexpected ack", 32'h0, 32'h1);
            end else begin
                chk("rdata", exp_q.pop_front(), rsp.rdata);
            end
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        void'($urandom(32'h6ba69a7a));
        repeat (3) @(posedge clock_in);
        nrst_in <= 1'b1;
        cfg(1, 0, OFF_TENURE_LINE, 0, 32'h0);
        cfg(1, 0, OFF_LINK_BASE, 0, 32'h0);
        cfg(1, 0, OFF_VENDOR_BASE, 0, 32'h0);
        cfg(0, 1, OFF_TENURE_LINE, 32'hffffffff, 0);
        cfg(1, 0, OFF_TENURE_LINE, 0, 32'h0000ffff);
        chk("line", 32'hff, {24'h0, line_len});
        // Sizing write and read back to back
        @(posedge clock_in);
        req <= {2'b01, OFF_LINK_BASE, 4'hf, 32'hffffffff};
        @(posedge clock_in);
        req <= {2'b10, OFF_LINK_BASE, 4'hf, 32'h00000000};
        exp_q.push_back(32'hfffff800);
        @(posedge clock_in);
        req <= '0;
        cfg(1, 0, 8'h20, 0, 32'h0);
        // Random pointers, the vendor one inverted so they differ
        for (int i = 0; i < 4; i++) begin
            w = $urandom;
            cfg(0, 1, OFF_LINK_BASE, w, 0);
            cfg(0, 1, OFF_VENDOR_BASE, ~w, 0);
            cfg(1, 0, OFF_LINK_BASE, 0,
                {w[31:11], 11'h0});
            cfg(1, 0, OFF_VENDOR_BASE, 0,
                {~w[31:11], 11'h0});
            chk("link ptr", {11'h0, w[31:11]}, {11'h0, link_ptr});
            chk("ven ptr", {11'h0, ~w[31:11]}, {11'h0, ven_ptr});
        end
        // Limit two in the upper byte, line length left as is
        @(posedge clock_in);
        req <= {1'b0, 1'b1, OFF_TENURE_LINE, 4'h2, 32'h0000_0200};
        @(posedge clock_in);
        req <= '0;
        tenure(1'b1, 1'b1);
        tenure(1'b0, 1'b1);
        // Limit out of reach: no stop although the grant is gone
        cfg(0, 1, OFF_TENURE_LINE, 32'h0000ffff, 0);
        tenure(1'b1, 1'b0);
        chk("line kept", 32'hff, {24'h0, line_len});
        end_sim;
    end

    // Cuts a hang short; the tests need well under 500 cycles
    initial begin
        repeat (5000) @(posedge clock_in);
        $display("BAD watchdog expected done seen timeout");
        err_count++;
        end_sim;
    end
endmodule

`default_nettype wire
